// ==== following_error_and_soft_limit_monitor.sv ====
// multi-motor following error and software limit monitor with AXI4-Lite registers
`timescale 1ns/100ps
module following_error_and_soft_limit_monitor
  import motor_safety_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [motor_safety_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [motor_safety_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // servo loop inputs: shared servo_tick, then one slice per motor
  input wire logic servo_tick,
  input wire logic [motor_safety_pkg::NUM_MOTORS-1:0][motor_safety_pkg::FE_W-1:0] following_error,
  input wire logic [motor_safety_pkg::NUM_MOTORS-1:0][motor_safety_pkg::POS_W-1:0] motor_position,
  input wire logic [motor_safety_pkg::NUM_MOTORS-1:0] homing_search,
  input wire logic [motor_safety_pkg::NUM_MOTORS-1:0] home_found,
  input wire logic [motor_safety_pkg::NUM_MOTORS-1:0][motor_safety_pkg::INC_W-1:0] move_incr_in,
  input wire logic [motor_safety_pkg::NUM_MOTORS-1:0][motor_safety_pkg::CMD_W-1:0] out_cmd_in,
  // control panel and jumper
  input wire logic control_panel_port,
  input wire logic warn_route_jumper,
  // warning outputs
  output logic panel_warn_out_n,
  output logic warn_interrupt_line,
  output logic machine_fault_out_n,
  output logic irq,
  // per-motor results
  output logic [motor_safety_pkg::NUM_MOTORS-1:0] motor_warn,
  output logic [motor_safety_pkg::NUM_MOTORS-1:0] motor_killed,
  output logic [motor_safety_pkg::NUM_MOTORS-1:0] home_trigger,
  output logic [motor_safety_pkg::NUM_MOTORS-1:0] pos_blocked,
  output logic [motor_safety_pkg::NUM_MOTORS-1:0] neg_blocked,
  output logic [motor_safety_pkg::NUM_MOTORS-1:0] limit_stop_req,
  output logic [motor_safety_pkg::NUM_MOTORS-1:0][motor_safety_pkg::DECEL_W-1:0] limit_decel_rate,
  output logic [motor_safety_pkg::NUM_MOTORS-1:0][motor_safety_pkg::INC_W-1:0] move_incr_out,
  output logic [motor_safety_pkg::NUM_MOTORS-1:0][motor_safety_pkg::CMD_W-1:0] out_cmd_out,
  // per coordinate system
  output logic [motor_safety_pkg::NUM_CS-1:0] program_abort
);
  import motor_safety_pkg::*;

  // settings
  logic panel_select_mode_r;
  logic host_cs_r;
  logic [LIM_W-1:0] warn_lim_r [NUM_MOTORS];
  logic [LIM_W-1:0] fatal_lim_r [NUM_MOTORS];
  logic [POS_W-1:0] pos_lim_r [NUM_MOTORS];
  logic [POS_W-1:0] neg_lim_r [NUM_MOTORS];
  logic [DECEL_W-1:0] decel_r [NUM_MOTORS];
  logic [31:0] fb_flags_r [NUM_MOTORS];
  logic [31:0] flag_ctl_r [NUM_MOTORS];
  logic [1:0] cs_map_r [NUM_MOTORS];
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [NUM_MOTORS-1:0] kill_clr_r;

  // bus state
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go;
  logic wr_hit;
  logic [31:0] rd_data;
  logic rd_hit;

  // monitor outputs
  logic [NUM_MOTORS-1:0] warn_evt_w;
  logic [NUM_MOTORS-1:0] fatal_evt_w;
  logic [NUM_CS-1:0] cs_warn;
  logic [NUM_CS-1:0] cs_fatal;
  logic sel_cs;
  logic sel_warn;
  logic [IRQ_W-1:0] irq_set;

  genvar g;
  generate
    for (g = 0; g < NUM_MOTORS; g++) begin : g_motor
      motor_monitor u_mon (
        .aclk(aclk),
        .aresetn(aresetn),
        .servo_tick(servo_tick),
        .following_error(following_error[g]),
        .motor_position(motor_position[g]),
        .homing_search(homing_search[g]),
        .home_found(home_found[g]),
        .move_incr_in(move_incr_in[g]),
        .out_cmd_in(out_cmd_in[g]),
        .warn_error_limit(warn_lim_r[g]),
        .fatal_error_limit(fatal_lim_r[g]),
        .positive_soft_limit(pos_lim_r[g]),
        .negative_soft_limit(neg_lim_r[g]),
        .trig_enable(fb_flags_r[g][TRIG_EN_BIT]),
        .kill_clear(kill_clr_r[g]),
        .warn_r(motor_warn[g]),
        .killed_r(motor_killed[g]),
        .trigger_r(home_trigger[g]),
        .pos_trip_r(pos_blocked[g]),
        .neg_trip_r(neg_blocked[g]),
        .warn_evt_r(warn_evt_w[g]),
        .fatal_evt_r(fatal_evt_w[g]),
        .stop_req_r(limit_stop_req[g]),
        .move_incr_out_r(move_incr_out[g]),
        .out_cmd_out_r(out_cmd_out[g])
      );
      // decel rate travels with the stop request to the trajectory stage
      assign limit_decel_rate[g] = decel_r[g];
    end
  endgenerate

  // system warning and abort gathered from assigned motors
  always_comb begin
    cs_warn = '0;
    cs_fatal = '0;
    for (int m = 0; m < NUM_MOTORS; m++) begin
      if (cs_map_r[m][CS_ASSIGN_BIT]) begin
        cs_warn[cs_map_r[m][CS_INDEX_BIT]] = cs_warn[cs_map_r[m][CS_INDEX_BIT]]
                                             | motor_warn[m];
        cs_fatal[cs_map_r[m][CS_INDEX_BIT]] = cs_fatal[cs_map_r[m][CS_INDEX_BIT]]
                                              | fatal_evt_w[m];
      end
    end
    sel_cs = panel_select_mode_r ? host_cs_r : control_panel_port;
    sel_warn = cs_warn[sel_cs];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      panel_warn_out_n <= 1'b1;
      warn_interrupt_line <= 1'b0;
      machine_fault_out_n <= 1'b1;
      program_abort <= '0;
    end else begin
      panel_warn_out_n <= !sel_warn;
      warn_interrupt_line <= sel_warn;
      machine_fault_out_n <= !(sel_warn && warn_route_jumper);
      program_abort <= cs_fatal;
    end
  end

  // axi4-lite write side; a low ready means that channel's word is held
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_hit = 1'b0;
    if (awaddr_r[ADDR_W-1:6] == '0) begin
      wr_hit = (awaddr_r[5:0] <= KILL_CLR_OFS[5:0]) && (awaddr_r[1:0] == 2'b00)
               && (awaddr_r != STATUS_OFS);
    end else if (awaddr_r[ADDR_W-1:6] >= MOTOR_PAGE_BASE
                 && awaddr_r[ADDR_W-1:6] < MOTOR_PAGE_BASE + 6'(NUM_MOTORS)) begin
      wr_hit = (awaddr_r[5:2] <= CS_MAP_IDX) && (awaddr_r[1:0] == 2'b00);
    end
  end

  // settings only change on a full-word write; partial strobes are ignored, except that kill clear acts on wstrb_r[0] alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      panel_select_mode_r <= 1'b0;
      host_cs_r <= 1'b0;
      irq_mask_r <= '0;
      for (int m = 0; m < NUM_MOTORS; m++) begin
        warn_lim_r[m] <= WARN_LIM_RST;
        fatal_lim_r[m] <= FATAL_LIM_RST;
        pos_lim_r[m] <= SOFT_LIM_RST;
        neg_lim_r[m] <= SOFT_LIM_RST;
        decel_r[m] <= DECEL_RST;
        fb_flags_r[m] <= '0;
        flag_ctl_r[m] <= '0;
        cs_map_r[m] <= '0;
      end
    end else if (wr_go && wr_hit && wstrb_r == 4'hF) begin
      if (awaddr_r == CTRL_OFS) begin
        panel_select_mode_r <= wdata_r[CTRL_SELMODE_BIT];
        host_cs_r <= wdata_r[CTRL_HOSTCS_BIT];
      end
      if (awaddr_r == IRQ_MASK_OFS) begin
        irq_mask_r <= wdata_r[IRQ_W-1:0];
      end
      for (int m = 0; m < NUM_MOTORS; m++) begin
        if (awaddr_r[ADDR_W-1:6] == MOTOR_PAGE_BASE + 6'(m)) begin
          case (awaddr_r[5:2])
            WARN_IDX: warn_lim_r[m] <= wdata_r[LIM_W-1:0];
            FATAL_IDX: fatal_lim_r[m] <= wdata_r[LIM_W-1:0];
            POSLIM_LO_IDX: pos_lim_r[m][31:0] <= wdata_r;
            POSLIM_HI_IDX: pos_lim_r[m][POS_W-1:32] <= wdata_r[POS_W-33:0];
            NEGLIM_LO_IDX: neg_lim_r[m][31:0] <= wdata_r;
            NEGLIM_HI_IDX: neg_lim_r[m][POS_W-1:32] <= wdata_r[POS_W-33:0];
            // a zero rate would never stop the motor, so it is refused
            DECEL_IDX: begin
              if (wdata_r[DECEL_W-1:0] != '0) begin
                decel_r[m] <= wdata_r[DECEL_W-1:0];
              end
            end
            FB_FLAGS_IDX: fb_flags_r[m] <= wdata_r;
            FLAG_CTL_IDX: flag_ctl_r[m] <= wdata_r;
            CS_MAP_IDX: cs_map_r[m] <= wdata_r[1:0];
            default: ;
          endcase
        end
      end
    end
  end

  // kill clear is a one-cycle strobe per motor
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kill_clr_r <= '0;
    end else if (wr_go && awaddr_r == KILL_CLR_OFS && wstrb_r[0]) begin
      kill_clr_r <= wdata_r[NUM_MOTORS-1:0];
    end else begin
      kill_clr_r <= '0;
    end
  end

  // interrupts
  assign irq_set = {limit_stop_req, fatal_evt_w, warn_evt_w};
  // new events win over a write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= '0;
    end else if (wr_go && awaddr_r == IRQ_STAT_OFS && wstrb_r == 4'hF) begin
      irq_stat_r <= (irq_stat_r & ~wdata_r[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_r <= irq_stat_r | irq_set;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // axi4-lite read side
  always_comb begin
    rd_data = '0;
    rd_hit = 1'b0;
    if (s_axi_araddr[1:0] == 2'b00) begin
      case (s_axi_araddr)
        CTRL_OFS: begin
          rd_hit = 1'b1;
          rd_data[CTRL_SELMODE_BIT] = panel_select_mode_r;
          rd_data[CTRL_HOSTCS_BIT] = host_cs_r;
        end
        STATUS_OFS: begin
          rd_hit = 1'b1;
          rd_data[17:0] = {neg_blocked, pos_blocked, motor_killed, cs_warn, motor_warn};
        end
        IRQ_STAT_OFS: begin
          rd_hit = 1'b1;
          rd_data[IRQ_W-1:0] = irq_stat_r;
        end
        IRQ_MASK_OFS: begin
          rd_hit = 1'b1;
          rd_data[IRQ_W-1:0] = irq_mask_r;
        end
        KILL_CLR_OFS: rd_hit = 1'b1;
        default: begin
          for (int m = 0; m < NUM_MOTORS; m++) begin
            if (s_axi_araddr[ADDR_W-1:6] == MOTOR_PAGE_BASE + 6'(m)) begin
              rd_hit = s_axi_araddr[5:2] <= CS_MAP_IDX;
              case (s_axi_araddr[5:2])
                WARN_IDX: rd_data[LIM_W-1:0] = warn_lim_r[m];
                FATAL_IDX: rd_data[LIM_W-1:0] = fatal_lim_r[m];
                POSLIM_LO_IDX: rd_data = pos_lim_r[m][31:0];
                POSLIM_HI_IDX: rd_data[POS_W-33:0] = pos_lim_r[m][POS_W-1:32];
                NEGLIM_LO_IDX: rd_data = neg_lim_r[m][31:0];
                NEGLIM_HI_IDX: rd_data[POS_W-33:0] = neg_lim_r[m][POS_W-1:32];
                DECEL_IDX: rd_data[DECEL_W-1:0] = decel_r[m];
                FB_FLAGS_IDX: rd_data = fb_flags_r[m];
                FLAG_CTL_IDX: rd_data = flag_ctl_r[m];
                CS_MAP_IDX: rd_data[1:0] = cs_map_r[m];
                default: rd_data = '0;
              endcase
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ==== motor_safety_pkg.sv ====
// constants for the following error and software limit monitor
package motor_safety_pkg;
  localparam int NUM_MOTORS = 4;
  localparam int NUM_CS = 2;
  localparam int ADDR_W = 12;
  localparam int FE_W = 32;
  localparam int LIM_W = 23;
  localparam int POS_W = 36;
  localparam int DECEL_W = 24;
  localparam int INC_W = 24;
  localparam int CMD_W = 16;
  localparam int IRQ_W = 12;
  // global register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 12'h008;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 12'h00C;
  localparam logic [ADDR_W-1:0] KILL_CLR_OFS = 12'h010;
  // motor m occupies 0x100 + m*0x40, word index within the window below
  localparam logic [5:0] MOTOR_PAGE_BASE = 6'h04;
  localparam logic [3:0] WARN_IDX = 4'h0;
  localparam logic [3:0] FATAL_IDX = 4'h1;
  localparam logic [3:0] POSLIM_LO_IDX = 4'h2;
  localparam logic [3:0] POSLIM_HI_IDX = 4'h3;
  localparam logic [3:0] NEGLIM_LO_IDX = 4'h4;
  localparam logic [3:0] NEGLIM_HI_IDX = 4'h5;
  localparam logic [3:0] DECEL_IDX = 4'h6;
  localparam logic [3:0] FB_FLAGS_IDX = 4'h7;
  localparam logic [3:0] FLAG_CTL_IDX = 4'h8;
  localparam logic [3:0] CS_MAP_IDX = 4'h9;
  // field positions
  localparam int CTRL_SELMODE_BIT = 0;
  localparam int CTRL_HOSTCS_BIT = 1;
  localparam int TRIG_EN_BIT = 17;
  localparam int CS_ASSIGN_BIT = 0;
  localparam int CS_INDEX_BIT = 1;
  localparam int IRQ_WARN_LSB = 0;
  localparam int IRQ_FATAL_LSB = 4;
  localparam int IRQ_LIMIT_LSB = 8;
  // reset values; limits in 1/16 count, decel in counts/ms^2 with 16 fraction bits
  localparam logic [LIM_W-1:0] WARN_LIM_RST = 23'h003E80;
  localparam logic [LIM_W-1:0] FATAL_LIM_RST = 23'h007D00;
  localparam logic [DECEL_W-1:0] DECEL_RST = 24'h004000;
  localparam logic [POS_W-1:0] SOFT_LIM_RST = 36'h000000000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ==== motor_monitor.sv ====
// per-motor following error, fatal and software limit checks
`timescale 1ns/100ps
module motor_monitor
  import motor_safety_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // servo cycle and motion state
  input wire logic servo_tick,
  input wire logic signed [FE_W-1:0] following_error,
  input wire logic signed [POS_W-1:0] motor_position,
  input wire logic homing_search,
  input wire logic home_found,
  input wire logic signed [INC_W-1:0] move_incr_in,
  input wire logic signed [CMD_W-1:0] out_cmd_in,
  // settings
  input wire logic [LIM_W-1:0] warn_error_limit,
  input wire logic [LIM_W-1:0] fatal_error_limit,
  input wire logic signed [POS_W-1:0] positive_soft_limit,
  input wire logic signed [POS_W-1:0] negative_soft_limit,
  input wire logic trig_enable,
  input wire logic kill_clear,
  // results
  output logic warn_r,
  output logic killed_r,
  output logic trigger_r,
  output logic pos_trip_r,
  output logic neg_trip_r,
  output logic warn_evt_r,
  output logic fatal_evt_r,
  output logic stop_req_r,
  output logic signed [INC_W-1:0] move_incr_out_r,
  output logic signed [CMD_W-1:0] out_cmd_out_r
);
  logic [FE_W:0] abs_fe;
  logic fatal_hit;
  logic warn_hit;
  logic lim_active;
  logic pos_over;
  logic neg_over;

  // one extra bit so the most negative error still has a true magnitude
  always_comb begin
    abs_fe = following_error[FE_W-1] ? (FE_W+1)'(-{following_error[FE_W-1], following_error})
                                     : {1'b0, following_error};
    fatal_hit = (fatal_error_limit != '0) && (abs_fe > {10'h000, fatal_error_limit});
    // fatal outranks warning, so a warning limit above a nonzero fatal one never shows
    warn_hit = (warn_error_limit != '0) && (abs_fe > {10'h000, warn_error_limit})
               && !fatal_hit && !killed_r;
    lim_active = !(homing_search && !home_found);
    // position is the homed/power-up frame; presets never reach this input
    pos_over = lim_active && (positive_soft_limit != '0)
               && (motor_position > positive_soft_limit);
    neg_over = lim_active && (negative_soft_limit != '0)
               && (motor_position < negative_soft_limit);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      warn_r <= 1'b0;
      trigger_r <= 1'b0;
      pos_trip_r <= 1'b0;
      neg_trip_r <= 1'b0;
    end else if (servo_tick) begin
      warn_r <= warn_hit;
      trigger_r <= warn_hit && trig_enable;
      pos_trip_r <= pos_over;
      neg_trip_r <= neg_over;
    end
  end

  // a fatal trip in the same cycle as a clear keeps the motor killed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      killed_r <= 1'b0;
    end else if (servo_tick && fatal_hit) begin
      killed_r <= 1'b1;
    end else if (kill_clear) begin
      killed_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      warn_evt_r <= 1'b0;
      fatal_evt_r <= 1'b0;
      stop_req_r <= 1'b0;
    end else begin
      warn_evt_r <= servo_tick && warn_hit && !warn_r;
      fatal_evt_r <= servo_tick && fatal_hit && !killed_r;
      stop_req_r <= servo_tick && ((pos_over && !pos_trip_r) || (neg_over && !neg_trip_r));
    end
  end

  // refuse motion toward a tripped limit, nothing at all once killed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      move_incr_out_r <= '0;
      out_cmd_out_r <= '0;
    end else begin
      if (killed_r || (pos_trip_r && move_incr_in > 0) || (neg_trip_r && move_incr_in < 0)) begin
        move_incr_out_r <= '0;
      end else begin
        move_incr_out_r <= move_incr_in;
      end
      if (killed_r || (pos_trip_r && out_cmd_in > 0) || (neg_trip_r && out_cmd_in < 0)) begin
        out_cmd_out_r <= '0;
      end else begin
        out_cmd_out_r <= out_cmd_in;
      end
    end
  end
endmodule

// ==== fe_monitor_sva.sv ====
// port-level assertions for the following error and soft limit monitor
`timescale 1ns/100ps
module fe_monitor_sva
  import motor_safety_pkg::*;
(
  // clock, reset, servo inputs and route jumper
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic servo_tick,
  input wire logic [NUM_MOTORS-1:0][INC_W-1:0] move_incr_in,
  input wire logic warn_route_jumper,
  // observed outputs
  input wire logic panel_warn_out_n,
  input wire logic warn_interrupt_line,
  input wire logic machine_fault_out_n,
  input wire logic [NUM_MOTORS-1:0] motor_warn,
  input wire logic [NUM_MOTORS-1:0] motor_killed,
  input wire logic [NUM_MOTORS-1:0] home_trigger,
  input wire logic [NUM_MOTORS-1:0] pos_blocked,
  input wire logic [NUM_MOTORS-1:0] neg_blocked,
  input wire logic [NUM_MOTORS-1:0] limit_stop_req,
  input wire logic [NUM_MOTORS-1:0][INC_W-1:0] move_incr_out,
  input wire logic [NUM_MOTORS-1:0][CMD_W-1:0] out_cmd_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_panel_irq_agree: assert property (panel_warn_out_n == !warn_interrupt_line)
    else $error("panel lamp and interrupt line disagree");
  a_fault_via_jumper: assert property (machine_fault_out_n ==
    !(warn_interrupt_line && $past(warn_route_jumper))) else $error("fault output wrong");
  a_warn_on_tick: assert property (!servo_tick |=> $stable(motor_warn))
    else $error("warning moved without a servo tick");
  a_kill_no_warn: assert property ((motor_warn & motor_killed) == '0)
    else $error("killed motor shows a warning");
  a_trig_needs_warn: assert property ((home_trigger & ~motor_warn) == '0)
    else $error("trigger without warning");
  a_pos_gate: assert property (pos_blocked[0] && $signed(move_incr_in[0]) > 0
    |=> move_incr_out[0] == '0) else $error("positive motion passed a tripped limit");
  a_neg_gate: assert property (neg_blocked[0] && $signed(move_incr_in[0]) < 0
    |=> move_incr_out[0] == '0) else $error("negative motion passed a tripped limit");
  a_kill_gate: assert property (motor_killed[0]
    |=> move_incr_out[0] == '0 && out_cmd_out[0] == '0) else $error("killed motor moved");
  a_stop_pulse: assert property (limit_stop_req[0]
    |-> (pos_blocked[0] || neg_blocked[0]) ##1 !limit_stop_req[0]) else $error("bad stop pulse");
endmodule

bind following_error_and_soft_limit_monitor fe_monitor_sva chk (.*);

// ==== panel_model.sv ====
// control panel model: system selector switch and fault routing jumper
`timescale 1ns/100ps
module panel_model (
  // clock and bench settings
  input wire logic aclk,
  input wire logic cs_sel,
  input wire logic jmp,
  // panel side pins
  output logic control_panel_port,
  output logic warn_route_jumper
);
  // registered so a switch never moves on the sampling edge
  always_ff @(posedge aclk) begin
    control_panel_port <= cs_sel;
    warn_route_jumper <= jmp;
  end
endmodule

// ==== testbench.sv ====
// self-checking bench for the following error and soft limit monitor
`timescale 1ns/100ps
module testbench;
  import motor_safety_pkg::*;
  logic aclk = 0, aresetn = 0, servo_tick = 0, cs_sel = 0, jmp = 1, abort_seen = 0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, control_panel_port, warn_route_jumper, irq;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [NUM_MOTORS-1:0][FE_W-1:0] following_error = '0;
  logic [NUM_MOTORS-1:0][POS_W-1:0] motor_position = '0;
  logic [NUM_MOTORS-1:0] homing_search = '0, home_found = '0;
  logic [NUM_MOTORS-1:0][INC_W-1:0] move_incr_in = '0, move_incr_out;
  logic [NUM_MOTORS-1:0][CMD_W-1:0] out_cmd_in = '0, out_cmd_out;
  logic panel_warn_out_n, warn_interrupt_line, machine_fault_out_n;
  logic [NUM_MOTORS-1:0] motor_warn, motor_killed, home_trigger, pos_blocked, neg_blocked;
  logic [NUM_MOTORS-1:0] limit_stop_req;
  logic [NUM_MOTORS-1:0][DECEL_W-1:0] limit_decel_rate;
  logic [NUM_CS-1:0] program_abort;
  int err_count = 0, checks = 0;
  following_error_and_soft_limit_monitor dut (.*);
  panel_model panel (.*);
  initial forever #2.5 aclk = ~aclk;
  always @(posedge aclk) if (program_abort[0]) abort_seen <= 1;
  function logic [11:0] ma(input logic [3:0] i);
    return {MOTOR_PAGE_BASE, i, 2'b00};
  endfunction
  task chk(input logic [71:0] got, input logic [71:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    rsp = s_axi_bresp;
  endtask
  task rdr(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  // the slowest output (irq) lands two edges after the tick edge
  task settle;
    repeat (3) @(posedge aclk);
    #1;
  endtask
  task tick(input logic [FE_W-1:0] f, input logic [POS_W-1:0] p);
    @(posedge aclk);
    following_error[0] <= f;
    motor_position[0] <= p;
    servo_tick <= 1;
    @(posedge aclk);
    servo_tick <= 0;
    settle;
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // the run needs a few hundred cycles; this only catches a hung handshake
  initial begin
    #100000;
    err_count++;
    wrap_up;
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    rdr(ma(WARN_IDX));
    chk(rd, 16000);
    rdr(ma(FATAL_IDX));
    chk(rd, 32000);
    rdr(12'h7F0);
    chk(rsp, RESP_SLVERR);
    wr(STATUS_OFS, 0);
    chk(rsp, RESP_SLVERR);
    wr(ma(CS_MAP_IDX), 1);
    chk(rsp, RESP_OKAY);
    wr(IRQ_MASK_OFS, 1);
    tick(16000, 0);
    chk(motor_warn, 0);
    tick(-16001, 0);
    chk({motor_warn, panel_warn_out_n, warn_interrupt_line, machine_fault_out_n, irq}, 8'h15);
    rdr(STATUS_OFS);
    chk(rd[5:4], 2'b01);
    @(posedge aclk);
    jmp <= 0;
    settle;
    chk(machine_fault_out_n, 1);
    @(posedge aclk);
    cs_sel <= 1;
    settle;
    chk(warn_interrupt_line, 0);
    wr(CTRL_OFS, 1);
    settle;
    chk(warn_interrupt_line, 1);
    wr(CTRL_OFS, 3);
    settle;
    chk(warn_interrupt_line, 0);
    wr(IRQ_STAT_OFS, 1);
    settle;
    chk(irq, 0);
    wr(IRQ_MASK_OFS, 0);
    tick(0, 0);
    tick(-16001, 0);
    chk(irq, 0);
    wr(IRQ_MASK_OFS, 1);
    settle;
    chk(irq, 1);
    wr(ma(FB_FLAGS_IDX), 32'h00020000);
    tick(20000, 0);
    chk(home_trigger, 1);
    wr(ma(WARN_IDX), 0);
    tick(20000, 0);
    chk(motor_warn, 0);
    wr(ma(WARN_IDX), 40000);
    @(posedge aclk);
    move_incr_in[0] <= 5;
    out_cmd_in[0] <= -3;
    tick(45000, 0);
    chk({motor_warn, motor_killed, abort_seen, move_incr_out[0]}, {9'h003, 24'h0});
    tick(0, 0);
    wr(KILL_CLR_OFS, 1);
    settle;
    chk({motor_killed, move_incr_out[0]}, {4'h0, 24'h5});
    tick(0, 100);
    chk(pos_blocked, 0);
    wr(ma(POSLIM_LO_IDX), 50);
    tick(0, 100);
    chk({pos_blocked[0], move_incr_out[0], out_cmd_out[0], limit_decel_rate[0]}, {1'b1, 24'h0, 16'hFFFD, 24'h004000});
    wr(ma(FLAG_CTL_IDX), 32'h00020000);
    tick(0, 100);
    chk(pos_blocked, 1);
    @(posedge aclk);
    homing_search[0] <= 1;
    tick(0, 100);
    chk(pos_blocked, 0);
    @(posedge aclk);
    home_found[0] <= 1;
    tick(0, 100);
    chk(pos_blocked, 1);
    wr(ma(POSLIM_LO_IDX), 0);
    wr(ma(NEGLIM_HI_IDX), 32'h0000000F);
    wr(ma(NEGLIM_LO_IDX), 32'hFFFFFFCE);
    @(posedge aclk);
    move_incr_in[0] <= -5;
    out_cmd_in[0] <= 3;
    tick(0, -100);
    chk({neg_blocked[0], move_incr_out[0], out_cmd_out[0]}, {1'b1, 24'h0, 16'h0003});
    tick(0, -50);
    chk(neg_blocked, 0);
    wrap_up;
  end
endmodule
